// ---- inc/eep_pkg.sv ----
// constants, types and state records for the two-wire eeprom slave
//
// Overview of operation
// - slave only; never drives the clock line
// - data changes only while clock is low
// - start is data falling while clock high
// - stop is data rising; ends any command
// - address byte: class 1010 plus three straps
// - address lsb one reads, zero writes
// - without straps, select bits are zero
// - receiver acknowledges on the ninth clock
// - byte write: address, two offsets, data, stop
// - stop after write starts busy programming window
// - page buffer takes up to thirty-two bytes
// - page latched, offset wraps inside page
// - page committed one byte per cycle over 32 cycles
// - protect pin high blocks all writes
// - protect sampled before first data byte
// - memory starts erased to all ones
// - immediate read sends byte at current address
// - selective read loads address then reads
// - acked read continues, wraps whole memory
// - sample on rising, change on falling edge
package eep_pkg;

  // ----------------------------------------------------------------
  // bus and memory layout
  // ----------------------------------------------------------------
  localparam logic [3:0]  EEP_CLASS_CODE  = 4'hA;
  localparam int          EEP_ADDR_W      = 13;
  localparam int          EEP_DEPTH       = 8192;
  localparam int          EEP_PAGE_BYTES  = 32;
  localparam logic [7:0]  EEP_ERASED      = 8'hFF;
  localparam logic [12:0] EEP_ADDR_LAST   = 13'h1FFF;
  localparam logic [4:0]  EEP_PAGE_LAST   = 5'h1F;
  localparam logic [3:0]  EEP_BIT_ACK     = 4'h8;
  localparam logic [3:0]  EEP_BIT_ACKDONE = 4'h9;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int EEP_CLK_SYS_NS     = 40;
  localparam int EEP_PROG_TIME_NS   = 5_000_000;
  localparam int EEP_PROG_CYCLES    = EEP_PROG_TIME_NS / EEP_CLK_SYS_NS;
  localparam int EEP_TIMER_W        = 24;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EEP_ERASE, EEP_IDLE, EEP_DEVADDR, EEP_ADDR_HI,
    EEP_ADDR_LO, EEP_WDATA, EEP_RDATA, EEP_COMMIT
  } eep_state_e;

  typedef struct packed {
    logic [1:0]       scl_sy;
    logic [1:0]       sda_sy;
    logic             scl_d;
    logic             sda_d;
    logic [1:0]       wp_sy;
    logic [1:0][2:0]  strap_sy;
    logic [1:0]       done_sy;
    logic             done_d;
    eep_state_e       st;
    logic [3:0]       cnt;
    logic [7:0]       sh;
    logic [7:0]       tx;
    logic [7:0]       hi;
    logic             rw;
    logic             mack;
    logic             oe;
    logic             sda_o;
    logic             wp_lat;
    logic             wr_pend;
    logic [31:0]      pvalid;
    logic [4:0]       cidx;
    logic [12:0]      addr;
    logic             busy;
    logic             req_tgl;
  } eep_link_s;

  typedef struct packed {
    logic [1:0]             req_sy;
    logic                   req_d;
    logic                   run;
    logic [EEP_TIMER_W-1:0] timer;
    logic                   done_tgl;
    logic                   busy;
  } eep_sys_s;

endpackage : eep_pkg

// ---- testbench/eep_bus_master.sv ----
// two-wire bus master model that drives the clock and pulls data low
`timescale 1ns/1ns
module eep_bus_master (
  // timing reference
  input  wire logic clk_sys,
  // resolved data wire, pulled up when released
  input  wire logic sda,
  // master lines
  output logic      scl,
  output logic      m_oe
);
  initial
  begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  // quarter bit: long against the slave's input synchroniser delay
  task automatic step();
    repeat (3) @(negedge clk_sys);
  endtask : step

  // data only moves a quarter after the fall, so it is stable while clock is high
  task automatic pulse(output logic smp);
    step();
    scl = 1'b1;
    step();
    smp = sda;
    step();
    scl = 1'b0;
    step();
  endtask : pulse

  task automatic bus_start();
    m_oe = 1'b0;
    step();
    scl = 1'b1;
    step();
    m_oe = 1'b1;
    step();
    scl = 1'b0;
    step();
  endtask : bus_start

  // clock stays high after stop: it stands still between frames
  task automatic bus_stop();
    m_oe = 1'b1;
    step();
    scl = 1'b1;
    step();
    m_oe = 1'b0;
    step();
  endtask : bus_stop

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      m_oe = ~b[i];
      pulse(s);
    end
    m_oe = 1'b0;
    pulse(s);
    ack = ~s;
  endtask : wr_byte

  task automatic rd_byte(output logic [7:0] b, input logic mack);
    logic s;
    m_oe = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(s);
      b[i] = s;
    end
    m_oe = mack;
    pulse(s);
  endtask : rd_byte
endmodule : eep_bus_master

// ---- testbench/tb.sv ----
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/1ns
module tb;
  import eep_pkg::*;
  logic       clk_sys, clk_link, resetn, wp, scl, m_oe;
  logic       sda_o, sda_oe, prog_busy, busy_seen;
  logic [2:0] strap;
  logic [7:0] rb;
  logic       ak;
  int         fails, samples_checked, cyc, tries;
  // open drain: the slave only ever pulls to its drive level
  wire        sda = ~((sda_oe & ~sda_o) | m_oe);

  eep_slave #(.PROG_CYCLES(200), .HAS_STRAPS(1'b1)) eep_slave_i (
    .clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit2(strap[2]), .wp(wp), .prog_busy(prog_busy));
  eep_bus_master eep_bus_master_i (.clk_sys(clk_sys), .sda(sda), .scl(scl), .m_oe(m_oe));

  // ----------------------------------------------------------------
  // clocks, timeout
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_link = 1'b0;
    #2;
    forever
    begin
      #7 clk_link = 1'b1;
      #8 clk_link = 1'b0;
    end
  end
  always @(negedge clk_sys)
  begin
    cyc++;
    if (prog_busy === 1'b1)
      busy_seen = 1'b1;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [7:0] dev(input logic rd);
    return {4'hA, strap, rd};
  endfunction : dev

  task automatic wr_chk(input string what, input logic [7:0] b, input logic exp);
    eep_bus_master_i.wr_byte(b, ak);
    check(what, {7'h00, exp}, {7'h00, ak});
  endtask : wr_chk

  task automatic set_addr(input logic [12:0] a);
    eep_bus_master_i.bus_start();
    wr_chk("write select ack", dev(1'b0), 1'b1);
    wr_chk("offset high ack", {3'h0, a[12:8]}, 1'b1);
    wr_chk("offset low ack", a[7:0], 1'b1);
  endtask : set_addr

  task automatic read_list(input logic [7:0] exp [$]);
    wr_chk("read select ack", dev(1'b1), 1'b1);
    foreach (exp[i])
    begin
      eep_bus_master_i.rd_byte(rb, i < exp.size() - 1);
      check("read byte", exp[i], rb);
    end
    eep_bus_master_i.bus_stop();
  endtask : read_list

  task automatic read_from(input logic [12:0] a, input logic [7:0] exp [$]);
    set_addr(a);
    eep_bus_master_i.bus_start();
    read_list(exp);
  endtask : read_from

  task automatic poll_ready();
    tries = 0;
    do
    begin
      eep_bus_master_i.bus_start();
      eep_bus_master_i.wr_byte(dev(1'b0), ak);
      eep_bus_master_i.bus_stop();
      tries++;
    end while (ak !== 1'b1 && tries < 60);
    check("poll acked", 8'h01, {7'h00, ak});
  endtask : poll_ready

  task automatic write_list(input logic [12:0] a, input logic [7:0] d [$]);
    set_addr(a);
    foreach (d[i])
      wr_chk("data ack", d[i], 1'b1);
    busy_seen = 1'b0;
    eep_bus_master_i.bus_stop();
    poll_ready();
    check("refused polls", 8'h01, {7'h00, tries > 1});
    check("busy window seen", 8'h01, {7'h00, busy_seen});
  endtask : write_list

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_erased_and_byte();
    read_from(13'h0010, '{8'hFF, 8'hFF});
    write_list(13'h1FFF, '{8'h5A});
    read_from(13'h1FFF, '{8'h5A, 8'hFF});
    set_addr(13'h1FFF);
    eep_bus_master_i.bus_stop();
    eep_bus_master_i.bus_start();
    read_list('{8'h5A});
  endtask : s_erased_and_byte

  task automatic s_page_wrap();
    write_list(13'h003E, '{8'h11, 8'h22, 8'h33});
    read_from(13'h003E, '{8'h11, 8'h22});
    read_from(13'h0020, '{8'h33});
    eep_bus_master_i.bus_start();
    read_list('{8'hFF});
  endtask : s_page_wrap

  task automatic s_protect();
    wp = 1'b1;
    set_addr(13'h1FFF);
    wr_chk("protected data ack", 8'h00, 1'b0);
    eep_bus_master_i.bus_stop();
    wp = 1'b0;
    poll_ready();
    check("polls after refused write", 8'h01, tries[7:0]);
    read_from(13'h1FFF, '{8'h5A});
  endtask : s_protect

  task automatic s_no_match();
    eep_bus_master_i.bus_start();
    wr_chk("foreign select", {4'hA, ~strap, 1'b0}, 1'b0);
    wr_chk("ignored byte", dev(1'b0), 1'b0);
    eep_bus_master_i.bus_stop();
    eep_bus_master_i.bus_start();
    wr_chk("wrong class", {4'hB, strap, 1'b1}, 1'b0);
    eep_bus_master_i.bus_stop();
    strap = 3'b010;
    eep_bus_master_i.bus_start();
    wr_chk("moved strap select", dev(1'b0), 1'b1);
    eep_bus_master_i.bus_stop();
    strap = 3'b101;
  endtask : s_no_match

  initial
  begin
    resetn    = 1'b0;
    wp        = 1'b0;
    strap     = 3'b101;
    busy_seen = 1'b0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    // memory erase after reset keeps the bus refused for about 3100 cycles
    repeat (3200) @(negedge clk_sys);
    s_erased_and_byte();
    s_page_wrap();
    s_protect();
    s_no_match();
    report_and_stop();
  end
endmodule : tb

// ---- verilog/eep_slave.sv ----
// two-wire serial eeprom slave: bus front end, page buffer, memory, busy timer
`timescale 1ns/1ns
module eep_slave
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES = EEP_PROG_CYCLES,
  parameter bit HAS_STRAPS  = 1'b1
)(
  // system side
  input  wire logic clk_sys,
  input  wire logic resetn,
  // link sampling clock
  input  wire logic clk_link,
  // two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // straps and protect
  input  wire logic strap_addr_bit0,
  input  wire logic strap_addr_bit1,
  input  wire logic strap_addr_bit2,
  input  wire logic wp,
  // status
  output logic      prog_busy
);

  initial
  begin
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << EEP_TIMER_W))
      $error("PROG_CYCLES out of range");
  end

  // ----------------------------------------------------------------
  // reset into the link domain
  // ----------------------------------------------------------------
  logic [1:0] lrst_sy_r;
  logic       lrst_n;

  always_ff @(posedge clk_link)
  begin
    lrst_sy_r <= {lrst_sy_r[0], resetn};
  end
  assign lrst_n = lrst_sy_r[1];

  // ----------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------
  eep_link_s  q_r;
  eep_link_s  q_nxt;
  eep_sys_s   s_r;
  eep_sys_s   s_nxt;
  logic [7:0] mem_r [EEP_DEPTH];
  logic [7:0] pb_r [EEP_PAGE_BYTES];
  logic [7:0] rd_r;
  logic       mem_we;
  logic [12:0] mem_wa;
  logic [7:0] mem_wd;
  logic       pb_we;
  logic       load_w;
  logic       rise_w;
  logic       fall_w;
  logic       start_w;
  logic       stop_w;
  logic       match_w;
  logic [2:0] strap_w;

  // edges seen on the synchronised pins
  assign rise_w  = q_r.scl_sy[1] & ~q_r.scl_d;
  assign fall_w  = ~q_r.scl_sy[1] & q_r.scl_d;
  assign start_w = q_r.scl_sy[1] & q_r.scl_d & q_r.sda_d & ~q_r.sda_sy[1];
  assign stop_w  = q_r.scl_sy[1] & q_r.scl_d & ~q_r.sda_d & q_r.sda_sy[1];
  assign strap_w = HAS_STRAPS ? q_r.strap_sy[1] : 3'h0;
  assign match_w = (q_r.sh[7:4] == EEP_CLASS_CODE) && (q_r.sh[3:1] == strap_w);

  always_comb
  begin
    q_nxt           = q_r;
    q_nxt.scl_sy    = {q_r.scl_sy[0], scl_i};
    q_nxt.sda_sy    = {q_r.sda_sy[0], sda_i};
    q_nxt.scl_d     = q_r.scl_sy[1];
    q_nxt.sda_d     = q_r.sda_sy[1];
    q_nxt.wp_sy     = {q_r.wp_sy[0], wp};
    q_nxt.strap_sy  = {q_r.strap_sy[0], {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0}};
    q_nxt.done_sy   = {q_r.done_sy[0], s_r.done_tgl};
    q_nxt.done_d    = q_r.done_sy[1];
    q_nxt.sda_o     = 1'b0;
    mem_we          = 1'b0;
    mem_wa          = q_r.addr;
    mem_wd          = EEP_ERASED;
    pb_we           = 1'b0;
    load_w          = 1'b0;
    if (q_r.done_sy[1] != q_r.done_d)
      q_nxt.busy = 1'b0;
    case (q_r.st)
      EEP_ERASE:
      begin
        mem_we     = 1'b1;
        q_nxt.addr = q_r.addr + 13'h0001;
        if (q_r.addr == EEP_ADDR_LAST)
        begin
          q_nxt.st   = EEP_IDLE;
          q_nxt.busy = 1'b0;
        end
      end
      EEP_COMMIT:
      begin
        // loaded bytes land one per cycle, indexed by cidx, before the busy window opens
        mem_we     = q_r.pvalid[q_r.cidx];
        mem_wa     = {q_r.addr[12:5], q_r.cidx};
        mem_wd     = pb_r[q_r.cidx];
        q_nxt.cidx = q_r.cidx + 5'h01;
        if (q_r.cidx == EEP_PAGE_LAST)
        begin
          q_nxt.st      = EEP_IDLE;
          q_nxt.req_tgl = ~q_r.req_tgl;
          q_nxt.busy    = 1'b1;
          q_nxt.wr_pend = 1'b0;
          q_nxt.pvalid  = 32'h0000_0000;
        end
      end
      default:
      begin
        if (start_w)
        begin
          q_nxt.st      = EEP_DEVADDR;
          q_nxt.cnt     = 4'h0;
          q_nxt.oe      = 1'b0;
          q_nxt.wr_pend = 1'b0;
          q_nxt.pvalid  = 32'h0000_0000;
        end
        else if (stop_w)
        begin
          q_nxt.oe  = 1'b0;
          q_nxt.cnt = 4'h0;
          // a stop with no data byte leaves only the new address
          if (q_r.wr_pend)
          begin
            q_nxt.st   = EEP_COMMIT;
            q_nxt.cidx = 5'h00;
          end
          else
            q_nxt.st = EEP_IDLE;
        end
        else if (q_r.st != EEP_IDLE && rise_w)
        begin
          if (q_r.cnt < EEP_BIT_ACK)
          begin
            q_nxt.sh  = {q_r.sh[6:0], q_r.sda_sy[1]};
            q_nxt.cnt = q_r.cnt + 4'h1;
          end
          else if (q_r.cnt == EEP_BIT_ACKDONE)
            q_nxt.mack = ~q_r.sda_sy[1];
        end
        else if (q_r.st != EEP_IDLE && fall_w)
        begin
          if (q_r.cnt == EEP_BIT_ACK)
          begin
            q_nxt.cnt = EEP_BIT_ACKDONE;
            case (q_r.st)
              EEP_DEVADDR:
              begin
                if (match_w && !q_r.busy)
                begin
                  q_nxt.oe = 1'b1;
                  q_nxt.rw = q_r.sh[0];
                end
                else
                  q_nxt.st = EEP_IDLE;
              end
              EEP_ADDR_HI:
              begin
                q_nxt.oe = 1'b1;
                q_nxt.hi = q_r.sh;
              end
              EEP_ADDR_LO:
              begin
                q_nxt.oe   = 1'b1;
                q_nxt.addr = {q_r.hi[4:0], q_r.sh};
              end
              EEP_WDATA:
              begin
                if (q_r.wp_lat)
                begin
                  q_nxt.st      = EEP_IDLE;
                  q_nxt.wr_pend = 1'b0;
                end
                else
                begin
                  q_nxt.oe                    = 1'b1;
                  pb_we                       = 1'b1;
                  q_nxt.pvalid[q_r.addr[4:0]] = 1'b1;
                  q_nxt.addr = {q_r.addr[12:5], q_r.addr[4:0] + 5'h01};
                  q_nxt.wr_pend               = 1'b1;
                end
              end
              default:
                q_nxt.oe = 1'b0;  // read: hand the ack slot to the master
            endcase
          end
          else if (q_r.cnt == EEP_BIT_ACKDONE)
          begin
            q_nxt.cnt = 4'h0;
            q_nxt.oe  = 1'b0;
            case (q_r.st)
              EEP_DEVADDR:
                if (q_r.rw)
                begin
                  q_nxt.st = EEP_RDATA;
                  load_w   = 1'b1;
                end
                else
                  q_nxt.st = EEP_ADDR_HI;
              EEP_ADDR_HI:
                q_nxt.st = EEP_ADDR_LO;
              EEP_ADDR_LO:
              begin
                q_nxt.st     = EEP_WDATA;
                q_nxt.wp_lat = q_r.wp_sy[1];
              end
              EEP_RDATA:
                if (q_r.mack)
                  load_w = 1'b1;
                else
                  q_nxt.st = EEP_IDLE;
              default:
                q_nxt.st = q_r.st;
            endcase
            if (load_w)
            begin
              q_nxt.tx   = rd_r;
              q_nxt.oe   = ~rd_r[7];
              q_nxt.addr = q_r.addr + 13'h0001;
            end
          end
          else if (q_r.st == EEP_RDATA && q_r.cnt != 4'h0)
            q_nxt.oe = ~q_r.tx[3'(4'h7 - q_r.cnt)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_link)
  begin
    if (!lrst_n)
    begin
      q_r      <= '0;
      q_r.st   <= EEP_ERASE;
      q_r.busy <= 1'b1;
    end
    else
      q_r <= q_nxt;
  end

  // memory and page buffer: no reset; erase walk fills the memory, data bytes fill the page buffer
  always_ff @(posedge clk_link)
  begin
    if (mem_we)
      mem_r[mem_wa] <= mem_wd;
    if (pb_we)
      pb_r[q_r.addr[4:0]] <= q_r.sh;
    rd_r <= mem_r[q_r.addr];
  end

  // ----------------------------------------------------------------
  // system domain: programming window timer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.req_sy = {s_r.req_sy[0], q_r.req_tgl};
    s_nxt.req_d  = s_r.req_sy[1];
    if (s_r.req_sy[1] != s_r.req_d)
    begin
      s_nxt.run   = 1'b1;
      s_nxt.timer = EEP_TIMER_W'(PROG_CYCLES - 1);
    end
    else if (s_r.run)
    begin
      if (s_r.timer == '0)
      begin
        s_nxt.run      = 1'b0;
        s_nxt.done_tgl = ~s_r.done_tgl;
      end
      else
        s_nxt.timer = s_r.timer - EEP_TIMER_W'(1);
    end
    s_nxt.busy = s_nxt.run;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sda_o     = q_r.sda_o;
  assign sda_oe    = q_r.oe;
  assign prog_busy = s_r.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_dev_byte_end;
    q_r.st == EEP_DEVADDR && q_r.cnt == EEP_BIT_ACK && fall_w;
  endsequence

  property p_idle_released;
    @(posedge clk_link) disable iff (!lrst_n)
    q_r.st == EEP_IDLE |-> !q_r.oe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("driving bus while idle");

  property p_oe_on_fall;
    @(posedge clk_link) disable iff (!lrst_n)
    $changed(q_r.oe) |-> $past(fall_w | start_w | stop_w);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("data changed outside clock low");

  property p_busy_nack;
    @(posedge clk_link) disable iff (!lrst_n)
    s_dev_byte_end and q_r.busy |=> !q_r.oe && q_r.st == EEP_IDLE;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");

  property p_match_ack;
    @(posedge clk_link) disable iff (!lrst_n)
    s_dev_byte_end and match_w && !q_r.busy |=> q_r.oe && q_r.cnt == EEP_BIT_ACKDONE;
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("matching address not acked");

  property p_wp_refuse;
    @(posedge clk_link) disable iff (!lrst_n)
    q_r.st == EEP_WDATA && q_r.cnt == EEP_BIT_ACK && fall_w && q_r.wp_lat
      |=> !q_r.oe && !q_r.wr_pend;
  endproperty
  a_wp_refuse: assert property (p_wp_refuse) else $error("protected write accepted");

  property p_commit_once;
    @(posedge clk_link) disable iff (!lrst_n)
    stop_w && q_r.wr_pend && q_r.st != EEP_COMMIT
      |=> (q_r.st == EEP_COMMIT) [*8] ##25 $changed(q_r.req_tgl);
  endproperty
  a_commit_once: assert property (p_commit_once) else $error("page commit length wrong");

  property p_page_wrap;
    @(posedge clk_link) disable iff (!lrst_n)
    pb_we |=> q_r.addr[12:5] == $past(q_r.addr[12:5])
      && q_r.addr[4:0] == 5'($past(q_r.addr[4:0]) + 5'h01);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page offset wrong");

  property p_read_advance;
    @(posedge clk_link) disable iff (!lrst_n)
    load_w |=> q_r.addr == 13'($past(q_r.addr) + 13'h0001) && q_r.oe == !q_r.tx[7];
  endproperty
  a_read_advance: assert property (p_read_advance) else $error("read address not advanced");

  property p_start_restarts;
    @(posedge clk_link) disable iff (!lrst_n)
    start_w && q_r.st != EEP_ERASE && q_r.st != EEP_COMMIT
      |=> q_r.st == EEP_DEVADDR && q_r.cnt == 4'h0 && !q_r.oe;
  endproperty
  a_start_restarts: assert property (p_start_restarts) else $error("start not honoured");

  property p_timer_counts;
    @(posedge clk_sys) disable iff (!resetn)
    s_r.run && s_r.timer != '0 && s_r.req_sy[1] == s_r.req_d
      |=> s_r.timer == $past(s_r.timer) - EEP_TIMER_W'(1) && prog_busy;
  endproperty
  a_timer_counts: assert property (p_timer_counts) else $error("busy timer stalled");

endmodule : eep_slave
